// ==== hw/xsl_seq.sv ====
// Save and restore sequencer for extended state components 3 to 9
`timescale 1ns/100ps
// How it works
// - Bound registers: four 128-bit entries, two words each, at 16i.
// - Bounds config in bytes 7:0, bounds status in bytes 15:8.
// - Bounds components act only with save enable and feature bits 4:3 set.
// - Bounds instructions usable only when enable and both bounds bits set.
// - Eight 64-bit mask registers at bytes 8i+7:8i.
// - Upper halves: vector i upper 256 bits at bytes 32i+31:32i.
// - Outside long mode only upper halves 0 to 7 are saved or restored.
// - Upper sixteen vectors: vector i at bytes 64(i-16).
// - Upper sixteen vectors accessed only in long mode.
// - Vector components act only with save enable and bits 7:5 set.
// - Vector instructions usable only when enable and all three bits set.
// - Trace is supervisor component 8, nine 8-byte MSRs, control first.
// - Trace bytes from 72 reserved; supervisor save writes zeroes there.
// - Trace acts only with save enable and supervisor mask bit 8.
// - Save clears trace enable after control MSR, before other trace words.
// - Fault or VM exit during save restores original trace enable.
// - Restore with trace enable set faults before any trace state change.
// - Restore faults occur before trace enable is modified.
// - Protection key is user component 9, 32-bit register in bytes 3:0.
// - Protection key acts only with save enable and feature bit 9.
// - Restore access checks use rights held before the instruction.
module xsl_seq (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  // Control and enables
  input  wire logic               os_save_enable_bit_i,
  input  wire logic               start_i,
  input  wire xsl_pkg::xsl_req_type req_i,
  input  wire logic               abort_i,
  input  wire logic [31:0]        rights_now_i,
  input  wire logic               trace_enable_bit_i,
  // Save-area memory port
  output xsl_pkg::xsl_mem_type    mem_o,
  input  wire logic               mem_ready_i,
  input  wire logic [63:0]        mem_rdata_i,
  // State access
  output logic [3:0]              st_comp_o,
  output logic [6:0]              st_word_o,
  output logic                    st_load_o,
  output logic [63:0]             st_wdata_o,
  input  wire logic [63:0]        st_rdata_i,
  // Trace enable control
  output logic                    trace_en_wr_o,
  output logic                    trace_en_val_o,
  // Status
  output logic                    busy_o,
  output logic                    done_o,
  output logic                    gp_fault_o,
  output logic                    bounds_usable_o,
  output logic                    vector_usable_o
);

  typedef struct packed {
    xsl_pkg::xsl_state_type st;
    logic [9:0]             en;
    logic [3:0]             comp;
    logic [6:0]             word;
    logic [6:0]             last;
    logic                   restore;
    logic                   sup;
    logic                   trace_orig;
    logic                   trace_cleared;
    logic [31:0]            rights;
    xsl_pkg::xsl_mem_type   mem;
    logic [3:0]             st_comp;
    logic [6:0]             st_word;
    logic                   st_load;
    logic [63:0]            st_wdata;
    logic                   tr_wr;
    logic                   tr_val;
    logic                   done;
    logic                   gp;
  } xsl_regs_type;

  xsl_regs_type r_q;
  xsl_regs_type r_d;

  // Number of words a component spans; upper halves reduced outside long mode
  function automatic logic [7:0] comp_words(input logic [3:0] c, input logic lm, input logic rst);
    logic [7:0] n;
    n = 8'h00;
    unique case (c)
      xsl_pkg::COMP_BOUNDS_REGISTER_COMPONENT: n = xsl_pkg::WORDS_BOUNDS_REGISTER_COMPONENT;
      xsl_pkg::COMP_BOUNDS_CONTROL_COMPONENT: n = xsl_pkg::WORDS_BOUNDS_CONTROL_COMPONENT;
      xsl_pkg::COMP_MASK:   n = xsl_pkg::WORDS_MASK;
      xsl_pkg::COMP_UPHALF: n = lm ? xsl_pkg::WORDS_UPHALF : xsl_pkg::WORDS_UPH32;
      xsl_pkg::COMP_UP16:   n = xsl_pkg::WORDS_UP16;
      xsl_pkg::COMP_TRACE:  n = rst ? xsl_pkg::WORDS_TRACE : xsl_pkg::WORDS_TRACE_AREA;
      xsl_pkg::COMP_PKEY:   n = xsl_pkg::WORDS_PKEY;
      default:              n = 8'h00;
    endcase
    return n;
  endfunction

  // Next enabled component above c, zero when none
  function automatic logic [3:0] next_comp(input logic [9:0] en, input logic [3:0] c);
    logic [3:0] f;
    f = 4'h0;
    for (int k = 9; k >= 3; k--) begin
      if (en[k] && (4'(k) > c)) begin
        f = 4'(k);
      end
    end
    return f;
  endfunction

  logic [63:0] fm;
  logic        bnd_ok;
  logic        wv_ok;
  logic [9:0]  en_now;

  assign fm     = req_i.feature_mask;
  assign bnd_ok = os_save_enable_bit_i && (&fm[xsl_pkg::FM_BND_HI:xsl_pkg::FM_BND_LO]);
  assign wv_ok  = os_save_enable_bit_i && (&fm[xsl_pkg::FM_WV_HI:xsl_pkg::FM_WV_LO]);

  always_comb begin
    en_now = 10'h000;
    en_now[xsl_pkg::COMP_BOUNDS_REGISTER_COMPONENT] = bnd_ok && req_i.req_mask[xsl_pkg::COMP_BOUNDS_REGISTER_COMPONENT];
    en_now[xsl_pkg::COMP_BOUNDS_CONTROL_COMPONENT] = bnd_ok && req_i.req_mask[xsl_pkg::COMP_BOUNDS_CONTROL_COMPONENT];
    en_now[xsl_pkg::COMP_MASK]   = wv_ok && req_i.req_mask[xsl_pkg::COMP_MASK];
    en_now[xsl_pkg::COMP_UPHALF] = wv_ok && req_i.req_mask[xsl_pkg::COMP_UPHALF];
    en_now[xsl_pkg::COMP_UP16]   = wv_ok && req_i.long_mode && req_i.req_mask[xsl_pkg::COMP_UP16];
    en_now[xsl_pkg::COMP_TRACE]  = os_save_enable_bit_i && req_i.supervisor &&
                                   req_i.sup_mask[xsl_pkg::SS_TRACE] &&
                                   req_i.req_mask[xsl_pkg::COMP_TRACE];
    en_now[xsl_pkg::COMP_PKEY]   = os_save_enable_bit_i && fm[xsl_pkg::FM_PKEY] &&
                                   req_i.req_mask[xsl_pkg::COMP_PKEY];
  end

  always_comb begin
    r_d         = r_q;
    r_d.done    = 1'b0;
    r_d.gp      = 1'b0;
    r_d.tr_wr   = 1'b0;
    r_d.st_load = 1'b0;
    unique case (r_q.st)
      xsl_pkg::XSL_IDLE: begin
        r_d.mem.valid = 1'b0;
        if (start_i) begin
          r_d.en         = en_now;
          r_d.restore    = req_i.restore;
          r_d.sup        = req_i.supervisor;
          r_d.trace_orig = trace_enable_bit_i;
          r_d.trace_cleared = 1'b0;
          r_d.rights     = rights_now_i;
          r_d.comp       = 4'h0;
          r_d.st         = xsl_pkg::XSL_PICK;
          // Checked before any word moves so no trace state is touched
          if (req_i.restore && en_now[xsl_pkg::COMP_TRACE] && trace_enable_bit_i) begin
            r_d.st = xsl_pkg::XSL_FAULT;
          end
        end
      end
      xsl_pkg::XSL_PICK: begin
        r_d.comp = next_comp(r_q.en, r_q.comp);
        r_d.word = 7'h00;
        r_d.last = 7'(comp_words(next_comp(r_q.en, r_q.comp), req_i.long_mode, r_q.restore) - 8'h01);
        // Point state access at word 0 so the first saved word reads its own data
        r_d.st_comp = next_comp(r_q.en, r_q.comp);
        r_d.st_word = 7'h00;
        r_d.st   = (next_comp(r_q.en, r_q.comp) == 4'h0) ? xsl_pkg::XSL_DONE : xsl_pkg::XSL_XFER;
      end
      xsl_pkg::XSL_XFER: begin
        // Word index inside the section encodes the byte layout directly
        r_d.mem.valid  = 1'b1;
        r_d.mem.write  = !r_q.restore;
        r_d.mem.comp   = r_q.comp;
        r_d.mem.word   = r_q.word;
        r_d.mem.rights = r_q.rights;
        r_d.mem.data   = st_rdata_i;
        if (r_q.comp == xsl_pkg::COMP_TRACE && r_q.word >= xsl_pkg::WORDS_TRACE) begin
          r_d.mem.data = xsl_pkg::RESET_WORD;
        end
        if (r_q.comp == xsl_pkg::COMP_PKEY) begin
          r_d.mem.data = {32'h00000000, st_rdata_i[31:0] & xsl_pkg::PKEY_MASK_LO};
        end
        r_d.st = xsl_pkg::XSL_WAIT;
      end
      xsl_pkg::XSL_WAIT: begin
        if (abort_i) begin
          r_d.mem.valid = 1'b0;
          r_d.st        = xsl_pkg::XSL_FAULT;
        end else if (mem_ready_i) begin
          r_d.mem.valid = 1'b0;
          if (r_q.restore) begin
            r_d.st_load  = 1'b1;
            r_d.st_wdata = mem_rdata_i;
          end
          if (!r_q.restore && r_q.comp == xsl_pkg::COMP_TRACE && r_q.word == 7'h00) begin
            r_d.tr_wr  = 1'b1;
            r_d.tr_val = 1'b0;
            r_d.trace_cleared = 1'b1;
          end
          r_d.word = r_q.word + 7'h01;
          r_d.st   = (r_q.word == r_q.last) ? xsl_pkg::XSL_PICK : xsl_pkg::XSL_XFER;
        end
      end
      xsl_pkg::XSL_FAULT: begin
        // Restores never change trace enable, so only saves need the undo
        if (!r_q.restore && r_q.trace_cleared) begin
          r_d.tr_wr  = 1'b1;
          r_d.tr_val = r_q.trace_orig;
        end
        r_d.gp = 1'b1;
        r_d.st = xsl_pkg::XSL_IDLE;
      end
      xsl_pkg::XSL_DONE: begin
        r_d.done = 1'b1;
        r_d.st   = xsl_pkg::XSL_IDLE;
      end
      default: r_d.st = xsl_pkg::XSL_IDLE;
    endcase
    // Restore loads the accepted word; save moves on so the next XFER reads its own word
    if (r_q.st == xsl_pkg::XSL_WAIT && mem_ready_i && !abort_i) begin
      r_d.st_comp = r_q.comp;
      r_d.st_word = r_q.restore ? r_q.word : r_q.word + 7'h01;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign mem_o           = r_q.mem;
  assign st_comp_o       = r_q.st_comp;
  assign st_word_o       = r_q.st_word;
  assign st_load_o       = r_q.st_load;
  assign st_wdata_o      = r_q.st_wdata;
  assign trace_en_wr_o   = r_q.tr_wr;
  assign trace_en_val_o  = r_q.tr_val;
  assign busy_o          = (r_q.st != xsl_pkg::XSL_IDLE);
  assign done_o          = r_q.done;
  assign gp_fault_o      = r_q.gp;
  assign bounds_usable_o = bnd_ok;
  assign vector_usable_o = wv_ok;

  a_trace_first_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r_q.tr_wr && !r_q.tr_val && !r_q.restore && r_q.st != xsl_pkg::XSL_IDLE |->
    r_q.comp == xsl_pkg::COMP_TRACE && r_q.word == 7'h01 && !mem_o.valid)
    else $error("trace enable cleared at wrong word");
  a_restore_gp_early: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r_q.st == xsl_pkg::XSL_IDLE && start_i && req_i.restore && en_now[xsl_pkg::COMP_TRACE] &&
    trace_enable_bit_i |=> r_q.st == xsl_pkg::XSL_FAULT ##1 gp_fault_o && !st_load_o)
    else $error("restore with trace on did not fault cleanly");
  a_restore_no_trace: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r_q.restore |-> !trace_en_wr_o)
    else $error("restore touched trace enable");
  a_save_undo: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r_q.st == xsl_pkg::XSL_FAULT && !r_q.restore && r_q.trace_cleared |=>
    trace_en_wr_o && trace_en_val_o == $past(r_q.trace_orig))
    else $error("trace enable not put back");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    mem_o.valid && mem_o.write && mem_o.comp == xsl_pkg::COMP_TRACE && mem_o.word >= xsl_pkg::WORDS_TRACE
    |-> mem_o.data == xsl_pkg::RESET_WORD)
    else $error("reserved trace bytes not zero");
  a_up16_long: assert property (@(posedge clk_i) disable iff (!resetn_i)
    mem_o.valid && mem_o.comp == xsl_pkg::COMP_UP16 |-> r_q.en[xsl_pkg::COMP_UP16] && req_i.long_mode)
    else $error("upper sixteen vectors accessed while disabled");
  a_uphalf_short: assert property (@(posedge clk_i) disable iff (!resetn_i)
    mem_o.valid && mem_o.comp == xsl_pkg::COMP_UPHALF && !req_i.long_mode |-> mem_o.word < xsl_pkg::WORDS_UPH32)
    else $error("upper half beyond byte 255 outside long mode");
  a_rights_held: assert property (@(posedge clk_i) disable iff (!resetn_i)
    mem_o.valid |-> mem_o.rights == r_q.rights && $stable(r_q.rights))
    else $error("access rights changed mid instruction");
  a_skip_disabled: assert property (@(posedge clk_i) disable iff (!resetn_i)
    mem_o.valid |-> r_q.en[mem_o.comp])
    else $error("disabled component touched");

endmodule

// ==== pkg/xsl_pkg.sv ====
// Package with layout constants and carrier types for the extended state save sequencer
package xsl_pkg;

  // Component numbers
  localparam logic [3:0] COMP_BOUNDS_REGISTER_COMPONENT  = 4'h3;
  localparam logic [3:0] COMP_BOUNDS_CONTROL_COMPONENT  = 4'h4;
  localparam logic [3:0] COMP_MASK    = 4'h5;
  localparam logic [3:0] COMP_UPHALF  = 4'h6;
  localparam logic [3:0] COMP_UP16    = 4'h7;
  localparam logic [3:0] COMP_TRACE   = 4'h8;
  localparam logic [3:0] COMP_PKEY    = 4'h9;

  // Enable field positions
  localparam int FM_BND_LO   = 3;
  localparam int FM_BND_HI   = 4;
  localparam int FM_WV_LO    = 5;
  localparam int FM_WV_HI    = 7;
  localparam int SS_TRACE    = 8;
  localparam int FM_PKEY     = 9;
  localparam int TRACE_EN_BIT = 0;

  // Word counts per component, 64-bit words; eight bits so that 128 fits
  localparam logic [7:0] WORDS_BOUNDS_REGISTER_COMPONENT = 8'h08;
  localparam logic [7:0] WORDS_BOUNDS_CONTROL_COMPONENT = 8'h02;
  localparam logic [7:0] WORDS_MASK   = 8'h08;
  localparam logic [7:0] WORDS_UPHALF = 8'h40;
  localparam logic [7:0] WORDS_UPH32  = 8'h20;
  localparam logic [7:0] WORDS_UP16   = 8'h80;
  localparam logic [7:0] WORDS_TRACE  = 8'h09;
  localparam logic [7:0] WORDS_TRACE_AREA = 8'h10;
  localparam logic [7:0] WORDS_PKEY   = 8'h01;
  localparam logic [31:0] PKEY_MASK_LO = 32'hFFFFFFFF;

  // Reset values
  localparam logic [63:0] RESET_WORD  = 64'h0000000000000000;

  typedef enum logic [2:0] {
    XSL_IDLE  = 3'b000,
    XSL_PICK  = 3'b001,
    XSL_XFER  = 3'b010,
    XSL_WAIT  = 3'b011,
    XSL_FAULT = 3'b100,
    XSL_DONE  = 3'b101
  } xsl_state_type;

  // Instruction request
  typedef struct packed {
    logic        restore;
    logic        supervisor;
    logic        long_mode;
    logic [63:0] feature_mask;
    logic [63:0] sup_mask;
    logic [9:0]  req_mask;
  } xsl_req_type;

  // Save-area word access
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  comp;
    logic [6:0]  word;
    logic [63:0] data;
    logic [31:0] rights;
  } xsl_mem_type;

endpackage

// ==== tb/xsl_mem_model.sv ====
// Save-area memory model with prompt or stalled accept
`timescale 1ns/100ps
module xsl_mem_model (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  // Access from the sequencer
  input  wire xsl_pkg::xsl_mem_type mem_i,
  input  wire logic                 abort_i,
  input  wire logic                 slow_i,
  output logic                      ready_o,
  output logic [63:0]               rdata_o
);
  logic [63:0] mem [0:2047];
  int          cnt [0:15];
  logic [1:0]  ctr_q;
  logic [63:0] last_q;
  wire  [10:0] idx = {mem_i.comp, mem_i.word};
  assign ready_o = mem_i.valid && (!slow_i || ctr_q == 2'h3);
  // Stale read data inverted so it never passes for a fresh word
  assign rdata_o = ready_o ? mem[idx] : ~last_q;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctr_q <= 2'h0;
      last_q <= 64'h0;
    end else begin
      ctr_q <= ctr_q + 2'h1;
      last_q <= rdata_o;
      if (ready_o && !abort_i) begin
        cnt[mem_i.comp] <= cnt[mem_i.comp] + 1;
        if (mem_i.write) mem[idx] <= mem_i.data;
      end
    end
  end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the extended state save sequencer
`timescale 1ns/100ps
module tb;
  logic                 clk_i = 1'b0;
  logic                 resetn_i = 1'b0;
  logic                 os_i, start_i, abort_i, ready, slow, tr_en, ab_arm, saw_gp, saw_done;
  logic                 st_load, tr_wr, tr_val, busy, done, gp, bu, vu;
  logic [3:0]           st_comp;
  logic [6:0]           st_word;
  logic [31:0]          rights_i, rights_x, seed;
  logic [63:0]          rdata, st_wdata, st_rdata;
  logic [63:0]          st [0:2047];
  logic [63:0]          st0 [0:2047];
  logic [63:0]          mem0 [0:2047];
  xsl_pkg::xsl_req_type req;
  xsl_pkg::xsl_mem_type mem;
  int                   fails = 0;
  int                   comparisons = 0;

  always #20 clk_i = ~clk_i;
  assign st_rdata = st[{st_comp, st_word}];
  // Combinational so the abort lands while the trace word still waits
  assign abort_i = ab_arm && mem.valid && mem.comp == xsl_pkg::COMP_TRACE && mem.word == 7'h03;

  xsl_seq dut (.clk_i(clk_i), .resetn_i(resetn_i), .os_save_enable_bit_i(os_i), .start_i(start_i),
    .req_i(req), .abort_i(abort_i), .rights_now_i(rights_i), .trace_enable_bit_i(tr_en), .mem_o(mem),
    .mem_ready_i(ready), .mem_rdata_i(rdata), .st_comp_o(st_comp), .st_word_o(st_word),
    .st_load_o(st_load), .st_wdata_o(st_wdata), .st_rdata_i(st_rdata), .trace_en_wr_o(tr_wr),
    .trace_en_val_o(tr_val), .busy_o(busy), .done_o(done), .gp_fault_o(gp), .bounds_usable_o(bu),
    .vector_usable_o(vu));
  xsl_mem_model mdl (.clk_i(clk_i), .resetn_i(resetn_i), .mem_i(mem), .abort_i(abort_i),
    .slow_i(slow), .ready_o(ready), .rdata_o(rdata));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic results;
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic int nwords(int c);
    logic b, v;
    b = os_i && req.req_mask[c] && req.feature_mask[4:3] == 2'h3;
    v = os_i && req.req_mask[c] && req.feature_mask[7:5] == 3'h7;
    case (c)
      3: return b ? 8 : 0;
      4: return b ? 2 : 0;
      5: return v ? 8 : 0;
      6: return v ? (req.long_mode ? 64 : 32) : 0;
      7: return (v && req.long_mode) ? 128 : 0;
      8: return (os_i && req.req_mask[c] && req.supervisor && req.sup_mask[8]) ? (req.restore ? 9 : 16) : 0;
      default: return (os_i && req.req_mask[c] && req.feature_mask[9]) ? 1 : 0;
    endcase
  endfunction

  always @(posedge clk_i) begin
    if (tr_wr) tr_en <= tr_val;
    if (st_load) st[{st_comp, st_word}] <= st_wdata;
    if (gp) saw_gp <= 1'b1;
    if (done) saw_done <= 1'b1;
    if (mem.valid && ready && busy) chk({32'h0, mem.rights}, {32'h0, rights_x}, "rights");
  end

  task automatic run(input logic rst, lng, osv, trv, ab, input logic [63:0] fm, input logic n_gp);
    int nw;
    int k;
    logic [10:0] ix;
    logic [63:0] e, m;
    for (int i = 0; i < 2048; i++) begin
      seed = lfsr(seed);
      st[i] = {seed, ~seed};
      mdl.mem[i] = {~seed, seed};
    end
    st[{4'h8, 7'h00}][0] = trv;
    for (int i = 0; i < 16; i++) mdl.cnt[i] = 0;
    st0 = st;
    mem0 = mdl.mem;
    @(posedge clk_i);
    req <= '{restore: rst, supervisor: 1'b1, long_mode: lng, feature_mask: fm, sup_mask: 64'h100,
             req_mask: 10'h3FF};
    os_i <= osv;
    tr_en <= trv;
    ab_arm <= ab;
    slow <= ~slow;
    saw_gp <= 1'b0;
    saw_done <= 1'b0;
    rights_x = seed;
    rights_i <= seed;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    rights_i <= ~rights_x;
    for (k = 0; k < 4000; k++) begin
      @(negedge clk_i);
      if (!busy) break;
    end
    if (k == 4000) begin
      fails++;
      results();
    end
    repeat (3) @(posedge clk_i);
    ab_arm <= 1'b0;
    chk(saw_done, !n_gp && !ab, "done pulse");
    if (ab) begin
      chk(tr_en, 1'b1, "trace enable after abort");
      return;
    end
    chk(saw_gp, n_gp, "fault");
    if (!rst && trv && nwords(8) != 0) chk(tr_en, 1'b0, "trace enable after save");
    for (int c = 3; c < 10; c++) begin
      nw = n_gp ? 0 : nwords(c);
      chk(mdl.cnt[c], nw, "word count");
      for (int w = 0; w < 128; w++) begin
        ix = {c[3:0], w[6:0]};
        m = (c == 9 && w == 0 && nw > 0) ? 64'h00000000FFFFFFFF : 64'hFFFFFFFFFFFFFFFF;
        if (rst) begin
          e = (w < nw) ? mem0[ix] : st0[ix];
          chk(st[ix] & m, e & m, "restored word");
        end else begin
          e = (w < nw) ? ((c == 8 && w >= 9) ? 64'h0 : st0[ix]) : mem0[ix];
          chk(mdl.mem[ix] & m, e & m, "saved word");
        end
      end
    end
  endtask

  initial begin
    os_i = 1'b0;
    start_i = 1'b0;
    slow = 1'b0;
    tr_en = 1'b0;
    ab_arm = 1'b0;
    saw_gp = 1'b0;
    saw_done = 1'b0;
    rights_i = 32'h0;
    seed = 32'h0000000B;
    req = '0;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      os_i <= i[2];
      req.feature_mask <= {56'h0, i[1], 1'b1, i[0], i[0], 1'b1, 3'h0};
      @(negedge clk_i);
      chk(bu, i[2] && i[0], "bounds usable");
      chk(vu, i[2] && i[1] && i[0], "vector usable");
    end
    run(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 64'h3F8, 1'b0);
    run(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 64'h3F8, 1'b0);
    run(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 64'h3E8, 1'b0);
    run(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 64'h3F8, 1'b1);
    run(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 64'h3F8, 1'b0);
    run(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 64'h208, 1'b0);
    run(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 64'h3F8, 1'b0);
    run(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 64'h3F8, 1'b0);
    results();
  end
endmodule
